/* hw/cpr_params.svh */
// Constants for the calibration pattern read path.
`ifndef CPR_PARAMS_SVH
`define CPR_PARAMS_SVH

// Mode register select values on the bank address pins.
`define CPR_MODE0_SEL 3'h0
`define CPR_MODE3_SEL 3'h3
// Mode register 3 field positions.
`define CPR_MODE3_ENABLE_BIT 2
`define CPR_MODE3_LOC_HI 1
`define CPR_MODE3_LOC_LO 0
// Mode register 0 burst length field: 00 fixed eight, 01 on the fly, 10 fixed four.
`define CPR_MODE0_BL_HI 1
`define CPR_MODE0_BL_LO 0
`define CPR_BL_FIXED8 2'h0
`define CPR_BL_OTF 2'h1
`define CPR_BL_FIXED4 2'h2
// Address bit positions used during reads.
`define CPR_ADDR_NIBBLE_BIT 2
`define CPR_ADDR_CHOP_BIT 12
`define CPR_ADDR_PRECHARGE_BIT 10
// Location 00 pattern, burst position 0 in the least significant bit.
`define CPR_LOC0_PATTERN 8'haa
`define CPR_LOC_CALIB 2'h0
// Default read latency in command clock cycles.
`define CPR_DEFAULT_LATENCY 11
`define CPR_MAX_LATENCY 30
// Beats per chopped and full burst.
`define CPR_BEATS_CHOP 4'h4
`define CPR_BEATS_FULL 4'h8

`endif

/* hw/cpr_pattern_read.sv */
// Calibration pattern read path: command decode, mode registers and serial pattern output.
//
// How it works
// - Mode register 3 bit A2 enables patterns.
// - Enabled reads come from pattern register.
// - Location field picks the pattern source.
// - Autoprecharge read acts as plain read.
// - Reset still works while enabled.
// - Disabled: location ignored, array used.
// - Bit 0 serial; bits 7:1 copy or zero.
// - Address bit 2 picks chopped half.
// - Bit 12 chops on the fly if allowed.
// - All other address bits are ignored.
// - Same read latency as array reads.
// - Burst position 0 is least significant.
// - Location 00 returns alternating zero, one.
// - No-operation starts nothing, keeps ongoing work.
// - Deselect runs nothing new, finishes ongoing.
`timescale 1ns/1ps
`default_nettype none
`include "cpr_params.svh"
module cpr_pattern_read #(
  parameter int LATENCY = `CPR_DEFAULT_LATENCY,
  parameter bit COPY_LANE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cmd_clk,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_enable_n,
  input wire logic [2:0] bank_addr,
  input wire logic [13:0] addr,
  output logic [7:0] lower_byte_lane,
  output logic [7:0] upper_byte_lane,
  output logic lane_drive_en,
  output logic data_strobe,
  output logic data_strobe_en,
  output logic pattern_mode,
  output logic array_read_req,
  output logic array_autoprecharge_req,
  output logic array_write_req
);
  // ****************************************
  // Parameter checks
  // ****************************************
  if (LATENCY < 1 || LATENCY > `CPR_MAX_LATENCY) begin
    $error("LATENCY out of range");
  end

  // ****************************************
  // Pin sampling
  // ****************************************
  localparam int PIN_W = 1 + 4 + 3 + 14;
  logic [PIN_W-1:0] pins_sync;
  cpr_sync #(.WIDTH(PIN_W)) pin_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in({cmd_clk, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n,
               bank_addr, addr}),
    .sync_out(pins_sync)
  );
  logic clk_s;
  logic cs_n_s;
  logic ras_n_s;
  logic cas_n_s;
  logic we_n_s;
  logic [2:0] ba_s;
  logic [13:0] a_s;
  assign {clk_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, a_s} = pins_sync;

  // Pins are delayed together, so the sampled bundle stays consistent at each edge.
  logic clk_prev;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_s;
    end
  end
  logic rise;
  logic fall;
  assign rise = clk_s && !clk_prev;
  assign fall = !clk_s && clk_prev;

  // ****************************************
  // Command decode
  // ****************************************
  cpr_pkg::cpr_cmd_type cmd;
  always_comb begin
    if (cs_n_s) begin
      cmd = cpr_pkg::cpr_cmd_deselect;
    end else if (ras_n_s && cas_n_s && we_n_s) begin
      cmd = cpr_pkg::cpr_cmd_idle;
    end else if (!ras_n_s && !cas_n_s && !we_n_s) begin
      cmd = cpr_pkg::cpr_cmd_mode_set;
    end else if (ras_n_s && !cas_n_s && we_n_s) begin
      cmd = cpr_pkg::cpr_cmd_read;
    end else if (ras_n_s && !cas_n_s && !we_n_s) begin
      cmd = cpr_pkg::cpr_cmd_other;
    end else begin
      cmd = cpr_pkg::cpr_cmd_other;
    end
  end
  logic is_write;
  assign is_write = !cs_n_s && ras_n_s && !cas_n_s && !we_n_s;

  // ****************************************
  // Mode registers
  // ****************************************
  logic [1:0] burst_mode;
  logic [1:0] location;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pattern_mode <= 1'b0;
      location <= `CPR_LOC_CALIB;
      burst_mode <= `CPR_BL_FIXED8;
    end else if (rise && cmd == cpr_pkg::cpr_cmd_mode_set) begin
      if (ba_s == `CPR_MODE3_SEL) begin
        pattern_mode <= a_s[`CPR_MODE3_ENABLE_BIT];
        location <= a_s[`CPR_MODE3_LOC_HI:`CPR_MODE3_LOC_LO];
      end else if (ba_s == `CPR_MODE0_SEL) begin
        burst_mode <= a_s[`CPR_MODE0_BL_HI:`CPR_MODE0_BL_LO];
      end
    end
  end

  // ****************************************
  // Array hand-off when patterns are off
  // ****************************************
  logic read_now;
  assign read_now = rise && cmd == cpr_pkg::cpr_cmd_read;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      array_read_req <= 1'b0;
      array_autoprecharge_req <= 1'b0;
      array_write_req <= 1'b0;
    end else begin
      array_read_req <= read_now && !pattern_mode;
      // Autoprecharge is dropped while patterns are on.
      array_autoprecharge_req <= read_now && !pattern_mode && a_s[`CPR_ADDR_PRECHARGE_BIT];
      array_write_req <= rise && is_write && !pattern_mode;
    end
  end

  // ****************************************
  // Latency pipeline
  // ****************************************
  logic chop;
  always_comb begin
    if (burst_mode == `CPR_BL_FIXED4) begin
      chop = 1'b1;
    end else if (burst_mode == `CPR_BL_OTF) begin
      chop = !a_s[`CPR_ADDR_CHOP_BIT];
    end else begin
      chop = 1'b0;
    end
  end
  // One entry per command clock; launch, chop, nibble. Other address bits unused.
  logic [2:0] pipe [0:LATENCY-1];
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe[i] <= 3'h0;
      end
    end else if (rise) begin
      pipe[0] <= {read_now && pattern_mode, chop, a_s[`CPR_ADDR_NIBBLE_BIT]};
      for (int i = 1; i < LATENCY; i++) begin
        pipe[i] <= pipe[i-1];
      end
    end
  end

  // ****************************************
  // Serial burst output
  // ****************************************
  logic [7:0] pattern;
  always_comb begin
    if (location == `CPR_LOC_CALIB) begin
      pattern = `CPR_LOC0_PATTERN;
    end else begin
      pattern = 8'h00;
    end
  end
  logic [3:0] beats_left;
  logic [2:0] beat_pos;
  logic active;
  assign active = beats_left != 4'h0;
  logic start;
  assign start = rise && pipe[LATENCY-1][2];
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      beats_left <= 4'h0;
      beat_pos <= 3'h0;
    end else if (start) begin
      beats_left <= pipe[LATENCY-1][1] ? `CPR_BEATS_CHOP : `CPR_BEATS_FULL;
      beat_pos <= {pipe[LATENCY-1][0] & pipe[LATENCY-1][1], 2'h0};
    end else if ((rise || fall) && active) begin
      beats_left <= beats_left - 4'h1;
      beat_pos <= beat_pos + 3'h1;
    end
  end
  logic next_bit;
  assign next_bit = start ? pattern[{pipe[LATENCY-1][0] & pipe[LATENCY-1][1], 2'h0}]
                          : pattern[beat_pos + 3'h1];
  logic launch;
  assign launch = start || ((rise || fall) && beats_left > 4'h1);
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      lower_byte_lane <= 8'h00;
      upper_byte_lane <= 8'h00;
      lane_drive_en <= 1'b0;
      data_strobe <= 1'b0;
      data_strobe_en <= 1'b0;
    end else if (launch) begin
      lower_byte_lane <= {{7{next_bit & COPY_LANE}}, next_bit};
      upper_byte_lane <= {{7{next_bit & COPY_LANE}}, next_bit};
      lane_drive_en <= 1'b1;
      data_strobe_en <= 1'b1;
      data_strobe <= start ? 1'b1 : fall;
    end else if ((rise || fall) && active) begin
      lower_byte_lane <= 8'h00;
      upper_byte_lane <= 8'h00;
      lane_drive_en <= 1'b0;
      data_strobe_en <= 1'b0;
      data_strobe <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* hw/cpr_pkg.sv */
// Types shared by the calibration pattern read path.
`default_nettype none
package cpr_pkg;
  typedef enum logic [2:0] {
    cpr_cmd_mode_set,
    cpr_cmd_read,
    cpr_cmd_idle,
    cpr_cmd_deselect,
    cpr_cmd_other
  } cpr_cmd_type;
endpackage
`default_nettype wire

/* hw/cpr_sync.sv */
// Two flip-flop synchroniser for a bundle of pin levels.
`timescale 1ns/1ps
`default_nettype none
module cpr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule
`default_nettype wire

/* verif/cpr_ctl_model.sv */
// Memory controller model driving the command pins on a free-running clock.
`timescale 1ns/1ps
`default_nettype none
module cpr_ctl_model (
  output logic cmd_clk,
  output logic chip_select_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_enable_n,
  output logic [2:0] bank_addr,
  output logic [13:0] addr
);
  initial begin
    cmd_clk = 1'b0;
    {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'hf;
    bank_addr = 3'h0;
    addr = 14'h0000;
    #3.3;
    forever #40 cmd_clk = ~cmd_clk;
  end
  // Pins move at the fall so they are settled at the sampling rise.
  task automatic issue(input logic [3:0] pins, input logic [2:0] ba,
    input logic [13:0] a, input int gap);
    @(negedge cmd_clk);
    {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = pins;
    bank_addr = ba;
    addr = a;
    @(negedge cmd_clk);
    // Idle lines carry inverted values, so a stale field cannot pass as live.
    {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'h7;
    bank_addr = ~ba;
    addr = ~a;
    repeat (gap) @(negedge cmd_clk);
    chip_select_n = 1'b1;
  endtask
endmodule
`default_nettype wire

/* verif/cpr_pattern_read_properties.sv */
// Checker for the calibration pattern read path.
`timescale 1ns/1ps
`default_nettype none
module cpr_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] lower_byte_lane,
  input wire logic [7:0] upper_byte_lane,
  input wire logic lane_drive_en,
  input wire logic data_strobe,
  input wire logic data_strobe_en,
  input wire logic pattern_mode,
  input wire logic array_read_req,
  input wire logic array_autoprecharge_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // A beat spans half a command clock, five system cycles.
  sequence s_first_beat_low;
    (lower_byte_lane == 8'h00) [*4];
  endsequence
  property p_lanes;
    lane_drive_en |-> upper_byte_lane == lower_byte_lane &&
      (lower_byte_lane == 8'h00 || lower_byte_lane == 8'hff);
  endproperty
  property p_no_array;
    pattern_mode |-> !array_read_req;
  endproperty
  property p_no_ap;
    pattern_mode |-> !array_autoprecharge_req;
  endproperty
  property p_order;
    $rose(lane_drive_en) |-> s_first_beat_low ##2 lower_byte_lane == 8'hff;
  endproperty
  property p_burst_len;
    $rose(lane_drive_en) |-> lane_drive_en [*8] ##[13:34] !lane_drive_en;
  endproperty
  property p_strobe_en;
    data_strobe_en == lane_drive_en;
  endproperty
  // Strobe is high for the first two beats and low on the third.
  property p_strobe_lead;
    $rose(lane_drive_en) |-> data_strobe ##5 data_strobe ##5 !data_strobe;
  endproperty
  property p_reset;
    disable iff (1'b0) !reset_n |=> !pattern_mode && !lane_drive_en;
  endproperty
  property p_pulse;
    array_read_req |=> !array_read_req;
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane bits disagree");
  a_no_array: assert property (p_no_array) else $error("array read in pattern mode");
  a_no_ap: assert property (p_no_ap) else $error("autoprecharge in pattern mode");
  a_order: assert property (p_order) else $error("burst does not start 0 then 1");
  a_burst_len: assert property (p_burst_len) else $error("burst length wrong");
  a_strobe_en: assert property (p_strobe_en) else $error("strobe enable differs");
  a_strobe_lead: assert property (p_strobe_lead) else $error("strobe shape wrong");
  a_reset: assert property (p_reset) else $error("reset did not clear");
  a_pulse: assert property (p_pulse) else $error("array read not a pulse");
endmodule
bind cpr_pattern_read cpr_props u_props(.ref_clk, .reset_n, .lower_byte_lane, .data_strobe,
  .upper_byte_lane, .lane_drive_en, .data_strobe_en, .pattern_mode, .array_read_req,
  .array_autoprecharge_req);
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the calibration pattern read path.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk, reset_n, cmd_clk, chip_select_n, row_strobe_n, col_strobe_n;
  logic write_enable_n, full, lane_drive_en, data_strobe, data_strobe_en, pattern_mode;
  logic array_read_req, array_autoprecharge_req, array_write_req;
  logic [2:0] bank_addr;
  logic [13:0] addr, a;
  logic [7:0] lower_byte_lane, upper_byte_lane;
  logic [7:0] got = 8'h00;
  logic [11:0] q[$];
  logic [11:0] note;
  logic [2:0] reqs;
  assign reqs = {array_autoprecharge_req, array_write_req, array_read_req};
  int fail_count = 0, total_checks = 0, cnt = 0, beats = 0;
  cpr_pattern_read #(.LATENCY(4)) dut(.ref_clk, .reset_n, .cmd_clk, .chip_select_n,
    .row_strobe_n, .col_strobe_n, .write_enable_n, .bank_addr, .addr, .lower_byte_lane,
    .upper_byte_lane, .lane_drive_en, .data_strobe, .data_strobe_en, .pattern_mode,
    .array_read_req, .array_autoprecharge_req, .array_write_req);
  cpr_ctl_model ctl(.cmd_clk, .chip_select_n, .row_strobe_n, .col_strobe_n,
    .write_enable_n, .bank_addr, .addr);
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Only mode writes, reads and one write go out; no bank is opened, so all stay idle.
  // With a latency of four, a gap of seven deselects the part just before a full burst ends,
  // which must still finish, and the next command follows only after the burst.
  task automatic rd(input logic [13:0] v, input logic [11:0] exp);
    q.push_back(exp);
    ctl.issue(4'h5, 3'($urandom), v, 7);
  endtask
  // ****
  // Output watcher: a burst is sampled mid-beat, two cycles into each beat.
  // ****
  always @(posedge ref_clk) begin
    if (lane_drive_en) begin
      if (cnt % 5 == 2) begin
        got[beats] = lower_byte_lane[0];
        beats++;
      end
      cnt++;
    end else if (cnt != 0) begin
      check({beats[3:0], got}, q.size() ? q.pop_front() : 12'hfff, "burst");
      cnt = 0;
      beats = 0;
      got = 8'h00;
    end
    if (array_read_req | array_write_req | array_autoprecharge_req) begin
      note = q.size() ? q.pop_front() : 12'hfff;
      check({9'h0, reqs}, note, "array");
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    fail_count++;
    tally_and_finish;
  end
  initial begin
    reset_n = 1'b0;
    void'($urandom(32'hfd165a7f));
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    ctl.issue(4'h0, 3'h3, 14'h0003, 4);
    a = 14'($urandom) & 14'h2bf8;
    q.push_back(12'h001);
    ctl.issue(4'h5, 3'h1, a, 12);
    q.push_back(12'h002);
    ctl.issue(4'h4, 3'h2, a, 12);
    $display("test disabled done");
    for (int m = 0; m < 3; m++) begin
      ctl.issue(4'h0, 3'h0, 14'(m), 4);
      ctl.issue(4'h0, 3'h3, 14'h0004, 4);
      check(12'(pattern_mode), 12'h001, "mode");
      for (int k = 0; k < 2; k++) begin
        a = 14'($urandom) & 14'h2bf8;
        a[12] = k[0];
        a[10] = k[0];
        full = m == 0 || (m == 1 && k == 1);
        if (!full) a[2] = k[0];
        rd(a, full ? 12'h8aa : 12'h40a);
      end
      ctl.issue(4'h0, 3'h3, 14'h0000, 4);
      $display("test burst mode %0d done", m);
    end
    ctl.issue(4'h0, 3'h3, 14'h0004, 4);
    @(negedge ref_clk) reset_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(12'(pattern_mode), 12'h000, "reset");
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(14'h0000, 12'h001);
    check(12'(q.size()), 12'h000, "leftover");
    $display("test reset done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
